//--- hdl/ppo_ctl.sv
`timescale 1ns/10ps
module ppo_ctl
  import ppo_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire ppo_addr_t  sw_addr_i,
  input  wire ppo_byte_t  sw_wdata_i,
  input  wire logic       sw_wr_i,
  input  wire logic       sw_rd_i,
  output ppo_byte_t       sw_rdata_o,
  output logic            fifo_rdy_o,
  ppo_if.ctl              dev
);

  ppo_byte_t    ctrl_r;
  ppo_byte_t    period_r;
  ppo_byte_t    match_b_r;
  ppo_byte_t    cnt_r;
  ppo_strobe_t  cm_a_r;
  ppo_strobe_t  cm_b_r;
  ppo_addr_t    dev_addr_r;
  ppo_byte_t    dev_rdata_r;
  logic         rd_pend_r;
  ppo_byte_t    sw_rdata_r;
  ppo_req_t     fifo_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_fifo_r;

  wire          run      = ctrl_r[`PPO_F_RUN];
  wire ppo_chan_t chan   = ctrl_r[`PPO_F_CHAN];
  wire          hit_a    = run & (cnt_r == period_r);
  wire          hit_b    = run & (cnt_r == match_b_r);
  wire          full     = (cnt_fifo_r == 2'd2);
  wire          empty    = (cnt_fifo_r == 2'd0);
  wire          push_pat = sw_wr_i & (sw_addr_i == `PPO_C_PATTERN);
  wire          push_wr  = sw_wr_i & (sw_addr_i == `PPO_C_DEV_WDATA);
  wire          push_rd  = sw_wr_i & (sw_addr_i == `PPO_C_DEV_READ);
  wire          push     = (push_pat | push_wr | push_rd) & ~full;
  wire ppo_req_t head    = fifo_r[rp_r];
  wire          pop      = ~empty & dev.rdy;
  wire ppo_req_t new_req = '{rd: push_rd, addr: push_pat ? `PPO_A_ND_HI : dev_addr_r, data: sw_wdata_i};
  wire ppo_strobe_t onehot = ppo_strobe_t'(4'h1 << chan);

  assign fifo_rdy_o = ~full;
  assign dev.wr     = ~empty & ~head.rd;
  assign dev.rd     = ~empty & head.rd;
  assign dev.addr   = head.addr;
  assign dev.wdata  = head.data;
  assign dev.cm_a   = cm_a_r;
  assign dev.cm_b   = cm_b_r;
  assign sw_rdata_o = sw_rdata_r;

  // Software registers
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r     <= `PPO_RST_ZERO;
      period_r   <= `PPO_RST_PERIOD;
      match_b_r  <= `PPO_RST_MATCH_B;
      dev_addr_r <= '0;
    end else if (sw_wr_i) begin
      if (sw_addr_i == `PPO_C_CTRL)     ctrl_r     <= sw_wdata_i;
      if (sw_addr_i == `PPO_C_PERIOD)   period_r   <= sw_wdata_i;
      if (sw_addr_i == `PPO_C_MATCH_B)  match_b_r  <= sw_wdata_i;
      if (sw_addr_i == `PPO_C_DEV_ADDR) dev_addr_r <= sw_wdata_i[`PPO_AW-1:0];
    end
  end

  // Trigger timer, counter cleared on match A
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r  <= '0;
      cm_a_r <= '0;
      cm_b_r <= '0;
    end else begin
      cnt_r  <= (!run || hit_a) ? '0 : cnt_r + 8'h01;
      cm_a_r <= hit_a ? onehot : '0;
      cm_b_r <= hit_b ? onehot : '0;
    end
  end

  // Two-entry request buffer toward the device
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fifo_r[0]  <= '0;
      fifo_r[1]  <= '0;
      wp_r       <= 1'b0;
      rp_r       <= 1'b0;
      cnt_fifo_r <= 2'd0;
    end else begin
      if (push) begin
        fifo_r[wp_r] <= new_req;
        wp_r         <= ~wp_r;
      end
      if (pop) rp_r <= ~rp_r;
      cnt_fifo_r <= cnt_fifo_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // Device read-back and software read port
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_pend_r   <= 1'b0;
      dev_rdata_r <= '0;
      sw_rdata_r  <= '0;
    end else begin
      rd_pend_r <= dev.rd & dev.rdy;
      if (rd_pend_r) dev_rdata_r <= dev.rdata;
      if (sw_rd_i) begin
        unique case (sw_addr_i)
          `PPO_C_CTRL:      sw_rdata_r <= ctrl_r;
          `PPO_C_PERIOD:    sw_rdata_r <= period_r;
          `PPO_C_MATCH_B:   sw_rdata_r <= match_b_r;
          `PPO_C_DEV_ADDR:  sw_rdata_r <= {4'h0, dev_addr_r};
          `PPO_C_DEV_RDATA: sw_rdata_r <= dev_rdata_r;
          `PPO_C_STATUS:    sw_rdata_r <= {5'h00, rd_pend_r, empty, full};
          default:          sw_rdata_r <= '0;
        endcase
      end
    end
  end

endmodule // ppo_ctl

//--- hdl/ppo_dev.sv
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module ppo_dev
  import ppo_pkg::*;
(
  input  wire logic  mclk_i,
  input  wire logic  nrst_i,
  ppo_if.dev         bus
);

  function automatic logic chan_pick(input ppo_strobe_t vec, input ppo_chan_t sel);
    return vec[sel];
  endfunction

  function automatic logic [3:0] xfer(input logic [3:0] lat,
                                      input logic [3:0] nd,
                                      input logic [3:0] en,
                                      input logic       ev_a,
                                      input logic       ev_b,
                                      input logic       nov);
    logic [3:0] res;
    res = lat;
    if (ev_a) begin
      res = (lat & ~en) | (nd & en);
    end else if (nov && ev_b) begin
      res = lat & ~(en & ~nd);
    end
    return res;
  endfunction

  ppo_byte_t   trig_r;
  ppo_byte_t   mode_r;
  ppo_byte_t   en_r;
  ppo_byte_t   ddr_r;
  ppo_byte_t   latch_r;
  ppo_byte_t   nd_r;
  logic [1:0]  margin_r;
  ppo_byte_t   rdata_r;
  ppo_byte_t   pin_r;
  ppo_byte_t   oe_n_r;

  // Trigger selection per group
  wire ppo_chan_t sel3 = trig_r[`PPO_F_G3_SEL];
  wire ppo_chan_t sel2 = trig_r[`PPO_F_G2_SEL];
  wire          same_trig = (sel3 == sel2);
  wire          ev_a3 = chan_pick(bus.cm_a, sel3);
  wire          ev_b3 = chan_pick(bus.cm_b, sel3);
  wire          ev_a2 = chan_pick(bus.cm_a, sel2);
  wire          ev_b2 = chan_pick(bus.cm_b, sel2);
  wire          nov3 = mode_r[`PPO_F_G3_NOV];
  wire          nov2 = mode_r[`PPO_F_G2_NOV];
  wire          pol3 = mode_r[`PPO_F_G3_POL];
  wire          pol2 = mode_r[`PPO_F_G2_POL];

  // Address decode
  wire          hit_trig  = (bus.addr == `PPO_A_TRIG);
  wire          hit_mode  = (bus.addr == `PPO_A_MODE);
  wire          hit_nden  = (bus.addr == `PPO_A_NDEN);
  wire          hit_ddr   = (bus.addr == `PPO_A_DDR);
  wire          hit_latch = (bus.addr == `PPO_A_LATCH);
  wire          hit_nd_hi = (bus.addr == `PPO_A_ND_HI);
  wire          hit_nd_lo = (bus.addr == `PPO_A_ND_LO) & ~same_trig;

  // Groups touched by a pattern write
  wire          touch3 = hit_nd_hi;
  wire          touch2 = (hit_nd_hi & same_trig) | hit_nd_lo;
  wire          stall  = bus.wr & ((touch3 & margin_r[1]) | (touch2 & margin_r[0]));

  assign bus.rdy = ~stall;

  wire          wr_ok = bus.wr & ~stall;
  wire          rd_ok = bus.rd;

  // Pattern register nibble-lane write mask
  wire ppo_byte_t nd_mask = {{4{wr_ok & touch3}}, {4{wr_ok & touch2}}};
  wire ppo_byte_t nd_nxt  = (nd_r & ~nd_mask) | (bus.wdata & nd_mask);

  // Latch: transfer on trigger, software only where not enabled
  wire [3:0]    lat3_x = xfer(latch_r[`PPO_F_G3_BITS], nd_r[`PPO_F_G3_BITS], en_r[`PPO_F_G3_BITS],
                              ev_a3, ev_b3, nov3);
  wire [3:0]    lat2_x = xfer(latch_r[`PPO_F_G2_BITS], nd_r[`PPO_F_G2_BITS], en_r[`PPO_F_G2_BITS],
                              ev_a2, ev_b2, nov2);
  wire ppo_byte_t sw_lat_mask = {`PPO_DW{wr_ok & hit_latch}} & ~en_r;
  wire ppo_byte_t latch_nxt = ({lat3_x, lat2_x} & ~sw_lat_mask) | (bus.wdata & sw_lat_mask);

  // Non-overlap margin per group, from match B to match A
  wire          margin3_nxt = ev_a3 ? 1'b0 : ((nov3 & ev_b3) ? 1'b1 : (margin_r[1] & nov3));
  wire          margin2_nxt = ev_a2 ? 1'b0 : ((nov2 & ev_b2) ? 1'b1 : (margin_r[0] & nov2));

  // Pin drive: polarity after the latch
  wire [3:0]    pin3 = pol3 ? latch_r[`PPO_F_G3_BITS] : ~latch_r[`PPO_F_G3_BITS];
  wire [3:0]    pin2 = pol2 ? latch_r[`PPO_F_G2_BITS] : ~latch_r[`PPO_F_G2_BITS];
  wire ppo_byte_t oe_n_nxt = ~(ddr_r & en_r);

  // Read mux
  wire ppo_byte_t nd_hi_rd = same_trig ? nd_r : {nd_r[`PPO_F_G3_BITS], 4'hf};
  wire ppo_byte_t nd_lo_rd = {4'hf, nd_r[`PPO_F_G2_BITS]};
  wire ppo_byte_t rd_mux =
      hit_trig  ? trig_r   :
      hit_mode  ? mode_r   :
      hit_nden  ? en_r     :
      hit_ddr   ? ddr_r    :
      hit_latch ? latch_r  :
      hit_nd_hi ? nd_hi_rd :
      hit_nd_lo ? nd_lo_rd :
      (bus.addr == `PPO_A_PINS) ? pin_r : 8'h00;

  assign bus.rdata    = rdata_r;
  assign bus.pin      = pin_r;
  assign bus.pin_oe_n = oe_n_r;

  // Trigger select register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_r <= `PPO_RST_TRIG;
    end else if (wr_ok && hit_trig) begin
      trig_r <= bus.wdata;
    end
  end

  // Output mode register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_r <= `PPO_RST_MODE;
    end else if (wr_ok && hit_mode) begin
      mode_r <= bus.wdata;
    end
  end

  // Next data enable register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_r <= `PPO_RST_ZERO;
    end else if (wr_ok && hit_nden) begin
      en_r <= bus.wdata;
    end
  end

  // Port direction register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ddr_r <= `PPO_RST_ZERO;
    end else if (wr_ok && hit_ddr) begin
      ddr_r <= bus.wdata;
    end
  end

  // Next pattern bits
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nd_r <= `PPO_RST_ZERO;
    end else begin
      nd_r <= nd_nxt;
    end
  end

  // Output latch
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      latch_r <= `PPO_RST_ZERO;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // Non-overlap margin flags
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      margin_r <= 2'b00;
    end else begin
      margin_r <= {margin3_nxt, margin2_nxt};
    end
  end

  // Pins and read data
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_r   <= `PPO_RST_ZERO;
      oe_n_r  <= 8'hff;
      rdata_r <= `PPO_RST_ZERO;
    end else begin
      pin_r  <= {pin3, pin2};
      oe_n_r <= oe_n_nxt;
      if (rd_ok) rdata_r <= rd_mux;
    end
  end

endmodule // ppo_dev

//--- shared/ppo_if.sv
`timescale 1ns/10ps
interface ppo_if;
  import ppo_pkg::*;

  logic         wr;
  logic         rd;
  ppo_addr_t    addr;
  ppo_byte_t    wdata;
  logic         rdy;
  ppo_byte_t    rdata;
  ppo_strobe_t  cm_a;
  ppo_strobe_t  cm_b;
  ppo_byte_t    pin;
  ppo_byte_t    pin_oe_n;

  modport dev (input wr, input rd, input addr, input wdata, output rdy, output rdata,
               input cm_a, input cm_b, output pin, output pin_oe_n);
  modport ctl (output wr, output rd, output addr, output wdata, input rdy, input rdata,
               output cm_a, output cm_b, input pin, input pin_oe_n);
endinterface

//--- shared/ppo_map.svh
`ifndef PPO_MAP_SVH
`define PPO_MAP_SVH

// Widths
`define PPO_DW            8
`define PPO_AW            4
`define PPO_NCH           4

// Device register offsets
`define PPO_A_TRIG        4'h0
`define PPO_A_MODE        4'h1
`define PPO_A_NDEN        4'h2
`define PPO_A_DDR         4'h3
`define PPO_A_LATCH       4'h4
`define PPO_A_ND_HI       4'h5
`define PPO_A_ND_LO       4'h6
`define PPO_A_PINS        4'h7

// Device reset values
`define PPO_RST_TRIG      8'hff
`define PPO_RST_MODE      8'hf0
`define PPO_RST_ZERO      8'h00

// Device field positions
`define PPO_F_G3_SEL      7:6
`define PPO_F_G2_SEL      5:4
`define PPO_F_G3_POL      7
`define PPO_F_G2_POL      6
`define PPO_F_G3_NOV      3
`define PPO_F_G2_NOV      2
`define PPO_F_G3_BITS     7:4
`define PPO_F_G2_BITS     3:0

// Controller register offsets
`define PPO_C_CTRL        4'h0
`define PPO_C_PERIOD      4'h1
`define PPO_C_MATCH_B     4'h2
`define PPO_C_PATTERN     4'h3
`define PPO_C_DEV_ADDR    4'h4
`define PPO_C_DEV_WDATA   4'h5
`define PPO_C_DEV_READ    4'h6
`define PPO_C_DEV_RDATA   4'h7
`define PPO_C_STATUS      4'h8

// Controller fields and reset values
`define PPO_F_RUN         0
`define PPO_F_CHAN        2:1
`define PPO_RST_PERIOD    8'hff
`define PPO_RST_MATCH_B   8'h00

`endif

//--- shared/ppo_pkg.sv
package ppo_pkg;
  `include "ppo_map.svh"

  typedef logic [1:0]           ppo_chan_t;
  typedef logic [`PPO_DW-1:0]   ppo_byte_t;
  typedef logic [`PPO_AW-1:0]   ppo_addr_t;
  typedef logic [`PPO_NCH-1:0]  ppo_strobe_t;

  typedef struct packed {
    logic       rd;
    ppo_addr_t  addr;
    ppo_byte_t  data;
  } ppo_req_t;
endpackage

//--- test/ppo_asserts.sv
`timescale 1ns/10ps
`include "ppo_map.svh"
module ppo_asserts
  import ppo_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic        wr,
  input wire logic        rd,
  input wire ppo_addr_t   addr,
  input wire ppo_byte_t   wdata,
  input wire logic        rdy,
  input wire ppo_byte_t   rdata,
  input wire ppo_strobe_t cm_a,
  input wire ppo_strobe_t cm_b,
  input wire ppo_byte_t   pin,
  input wire ppo_byte_t   pin_oe_n
);
  ppo_byte_t trig_r, mode_r, en_r, ddr_r, lat_r, nd_r;
  wire       tk   = wr & rdy;
  wire       same = trig_r[7:6] == trig_r[5:4];
  wire       a3   = cm_a[trig_r[7:6]];
  wire       a2   = cm_a[trig_r[5:4]];
  wire       b3   = cm_b[trig_r[7:6]] & mode_r[3] & ~a3;
  wire       b2   = cm_b[trig_r[5:4]] & mode_r[2] & ~a2;
  wire [7:0] ga   = {{4{a3}}, {4{a2}}} & en_r;
  wire [7:0] gb   = {{4{b3}}, {4{b2}}} & en_r & ~nd_r;
  wire [7:0] lsw  = (tk && addr == `PPO_A_LATCH) ? (lat_r & en_r) | (wdata & ~en_r) : lat_r;
  wire [7:0] lat_nxt = (lsw & ~ga & ~gb) | (nd_r & ga);
  wire [7:0] nd_nxt  = !tk ? nd_r : (addr == `PPO_A_ND_HI) ? (same ? wdata : {wdata[7:4], nd_r[3:0]}) :
                       (addr == `PPO_A_ND_LO && !same) ? {nd_r[7:4], wdata[3:0]} : nd_r;
  wire [7:0] pin_exp = lat_r ^ ~{{4{mode_r[7]}}, {4{mode_r[6]}}};
  wire [7:0] oe_exp  = ~(ddr_r & en_r);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_r <= `PPO_RST_TRIG;
      mode_r <= `PPO_RST_MODE;
      en_r   <= 8'h00;
      ddr_r  <= 8'h00;
      lat_r  <= 8'h00;
      nd_r   <= 8'h00;
    end else begin
      if (tk && addr == `PPO_A_TRIG) trig_r <= wdata;
      if (tk && addr == `PPO_A_MODE) mode_r <= wdata;
      if (tk && addr == `PPO_A_NDEN) en_r <= wdata;
      if (tk && addr == `PPO_A_DDR) ddr_r <= wdata;
      lat_r <= lat_nxt;
      nd_r  <= nd_nxt;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  a_pin_level: assert property (pin == $past(pin_exp))
    else $error("pin level differs from latch model");
  a_oe_enable: assert property (pin_oe_n == $past(oe_exp))
    else $error("output enable wrong");
  a_trig_read: assert property (rd && addr == `PPO_A_TRIG |=> rdata == $past(trig_r))
    else $error("trigger select readback wrong");
  a_mode_read: assert property (rd && addr == `PPO_A_MODE |=> rdata == $past(mode_r))
    else $error("output mode readback wrong");
  a_latch_read: assert property (rd && addr == `PPO_A_LATCH |=> rdata == $past(lat_r))
    else $error("latch readback wrong");
  a_low_half: assert property (rd && addr == `PPO_A_ND_LO |=>
    rdata == ($past(same) ? 8'h00 : ($past(nd_r) | 8'hf0)))
    else $error("low pattern half readback wrong");
  a_stall_cause: assert property (!rdy |-> wr && (addr == `PPO_A_ND_HI || addr == `PPO_A_ND_LO))
    else $error("stall without pattern write");
  a_normal_ignores_b: assert property (cm_b[trig_r[7:6]] && !mode_r[3] && !a3 &&
    !(tk && (addr == `PPO_A_LATCH || addr == `PPO_A_MODE)) |=> ##1 $stable(pin[7:4]))
    else $error("match B moved group 3 in normal mode");
  a_strobe_onehot: assert property ($onehot0(cm_a) && $onehot0(cm_b))
    else $error("compare strobes not one-hot");

  c_b_transfer: cover property (b3 && en_r != 8'h00);
  c_stall: cover property (!rdy);
  c_a_nonoverlap: cover property (a3 && mode_r[3]);
endmodule // ppo_asserts

//--- test/pulse_pattern_output_groups_tb.sv
`timescale 1ns/10ps
`include "ppo_map.svh"
module pulse_pattern_output_groups_tb;
  import ppo_pkg::*;
  logic      mclk_i   = 1'b0;
  logic      nrst_i   = 1'b0;
  ppo_addr_t sw_addr  = 4'h0;
  ppo_byte_t sw_wdata = 8'h00;
  logic      sw_wr    = 1'b0;
  logic      sw_rd    = 1'b0;
  ppo_byte_t sw_rdata;
  logic      fifo_rdy;
  ppo_byte_t v;
  int        failures = 0;
  int        compares = 0;
  int        cyc      = 0;

  ppo_if u_ppo_if ();
  ppo_ctl u_ppo_ctl (.mclk_i(mclk_i), .nrst_i(nrst_i), .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata),
    .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata), .fifo_rdy_o(fifo_rdy), .dev(u_ppo_if.ctl));
  ppo_dev u_ppo_dev (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus(u_ppo_if.dev));
  ppo_asserts u_ppo_asserts (.mclk_i(mclk_i), .nrst_i(nrst_i), .wr(u_ppo_if.wr), .rd(u_ppo_if.rd),
    .addr(u_ppo_if.addr), .wdata(u_ppo_if.wdata), .rdy(u_ppo_if.rdy), .rdata(u_ppo_if.rdata),
    .cm_a(u_ppo_if.cm_a), .cm_b(u_ppo_if.cm_b), .pin(u_ppo_if.pin), .pin_oe_n(u_ppo_if.pin_oe_n));

  always #2.5 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input ppo_byte_t e, input ppo_byte_t g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input ppo_addr_t a, input ppo_byte_t d);
    @(posedge mclk_i);
    sw_wr    <= 1'b1;
    sw_addr  <= a;
    sw_wdata <= d;
    @(posedge mclk_i);
    sw_wr <= 1'b0;
  endtask

  task automatic rd(input ppo_addr_t a, output ppo_byte_t d);
    @(posedge mclk_i);
    sw_rd   <= 1'b1;
    sw_addr <= a;
    @(posedge mclk_i);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask

  task automatic dw(input ppo_addr_t a, input ppo_byte_t d);
    wr(`PPO_C_DEV_ADDR, {4'h0, a});
    wr(`PPO_C_DEV_WDATA, d);
  endtask

  task automatic dchk(input string n, input ppo_addr_t a, input ppo_byte_t e);
    ppo_byte_t d;
    wr(`PPO_C_DEV_ADDR, {4'h0, a});
    wr(`PPO_C_DEV_READ, 8'h00);
    repeat (20) begin
      rd(`PPO_C_STATUS, d);
      if (d[1] && !d[2]) break;
    end
    rd(`PPO_C_DEV_RDATA, d);
    chk(n, e, d);
  endtask

  task automatic run(input logic [1:0] ch, input int n);
    wr(`PPO_C_CTRL, {5'h00, ch, 1'b1});
    repeat (n) @(posedge mclk_i);
    wr(`PPO_C_CTRL, 8'h00);
    repeat (4) @(posedge mclk_i);
  endtask

  initial begin
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    dchk("trig", `PPO_A_TRIG, 8'hff);
    dchk("mode", `PPO_A_MODE, 8'hf0);
    rd(4'hf, v);
    chk("unmapped", 8'h00, v);
    chk("oe_n", 8'hff, u_ppo_if.pin_oe_n);
    $display("test reset values done");
    dw(`PPO_A_NDEN, 8'hff);
    dw(`PPO_A_DDR, 8'hff);
    wr(`PPO_C_PERIOD, 8'h0f);
    v = 8'h00;
    for (int c = 0; c < 4; c++) begin
      dw(`PPO_A_TRIG, {c[1:0], c[1:0], 4'hf});
      wr(`PPO_C_PATTERN, ppo_byte_t'(8'h11 << c));
      run(c[1:0] + 2'd1, 40);
      chk("pin other channel", v, u_ppo_if.pin);
      run(c[1:0], 40);
      v = ppo_byte_t'(8'h11 << c);
      chk("pin own channel", v, u_ppo_if.pin);
    end
    chk("oe_n", 8'h00, u_ppo_if.pin_oe_n);
    $display("test trigger select done");
    dw(`PPO_A_MODE, 8'h70);
    dchk("mode", `PPO_A_MODE, 8'h70);
    chk("pin inverted", 8'h78, u_ppo_if.pin);
    dw(`PPO_A_MODE, 8'hf0);
    dw(`PPO_A_NDEN, 8'h00);
    dw(`PPO_A_LATCH, 8'h5a);
    dw(`PPO_A_DDR, 8'h0f);
    dchk("latch", `PPO_A_LATCH, 8'h5a);
    chk("pin preload", 8'h5a, u_ppo_if.pin);
    chk("oe_n", 8'hff, u_ppo_if.pin_oe_n);
    dw(`PPO_A_NDEN, 8'hf0);
    dw(`PPO_A_DDR, 8'hff);
    dw(`PPO_A_LATCH, 8'ha5);
    dchk("latch", `PPO_A_LATCH, 8'h55);
    chk("oe_n", 8'h0f, u_ppo_if.pin_oe_n);
    $display("test polarity and latch done");
    dw(`PPO_A_TRIG, 8'h4f);
    dw(`PPO_A_ND_HI, 8'hc3);
    dw(`PPO_A_ND_LO, 8'h3c);
    dchk("nd high", `PPO_A_ND_HI, 8'hcf);
    dchk("nd low", `PPO_A_ND_LO, 8'hfc);
    dw(`PPO_A_TRIG, 8'h0f);
    dchk("nd low shared", `PPO_A_ND_LO, 8'h00);
    dchk("nd shared", `PPO_A_ND_HI, 8'hcc);
    $display("test pattern halves done");
    dw(`PPO_A_NDEN, 8'hff);
    dw(`PPO_A_MODE, 8'hfc);
    wr(`PPO_C_PATTERN, 8'h95);
    wr(`PPO_C_PERIOD, 8'hff);
    wr(`PPO_C_MATCH_B, 8'h10);
    run(2'd0, 40);
    chk("pin after b", 8'h15, u_ppo_if.pin);
    wr(`PPO_C_PATTERN, 8'h65);
    wr(`PPO_C_PATTERN, 8'h56);
    #1 chk("fifo ready", 8'h00, {7'h00, fifo_rdy});
    wr(`PPO_C_PATTERN, 8'h59);
    wr(`PPO_C_CTRL, 8'h01);
    for (int i = 0; i < 600 && u_ppo_if.pin !== 8'h95; i++) begin
      @(posedge mclk_i);
      #1;
    end
    wr(`PPO_C_CTRL, 8'h00);
    chk("pin after a", 8'h95, u_ppo_if.pin);
    dchk("nd after margin", `PPO_A_ND_HI, 8'h56);
    chk("fifo ready", 8'h01, {7'h00, fifo_rdy});
    $display("test non-overlap done");
    final_report();
  end
endmodule // pulse_pattern_output_groups_tb
